// ==== inc/rimp_pkg.sv ====
// Function
// - after reset, input and output map writes are accepted until locked
// - mapping lock, control bit 11, blocks all input and output map writes
// - locked map writes finish normally with no error, contents unchanged
// - clearing the mapping lock lets map writes store again
// - lock bit changes only right after key writes 0x55 then 0xAA
// - input mapping is per peripheral input, one 8-bit selector each
// - each peripheral input takes the source indexed by its selector
// - selector 0 gives ground; 1 to 3 give comparators 1 to 3
// - selectors 6 and 7 give trigger generator outputs 26 and 27
// - selectors 11, 12, 13 give PWM event outputs C, D, E
// - selectors 32 to 47 give port B pins 0 to 15
// - selectors 48 to 61 give port C pins 0 to 13
// - selectors 65, 72, 74, 77 give port D pins 1, 8, 10, 13
// - selectors 176 to 181 give virtual pins 0 to 5
// - all other selector values are reserved, no source assigned
// - output map selectors reset to zero, the null output
package rimp_pkg;

  // write targets of the command port
  localparam logic [1:0] WR_IN_MAP = 2'h0;
  localparam logic [1:0] WR_OUT_MAP = 2'h1;
  localparam logic [1:0] WR_KEY = 2'h2;
  localparam logic [1:0] WR_CTRL = 2'h3;

  localparam int LOCK_BIT = 11;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic LOCK_RST = 1'h0;
  localparam logic [7:0] IN_SEL_RST = 8'h00;
  localparam logic [5:0] OUT_SEL_RST = 6'h00;

  localparam int IN_SEL_W = 8;
  localparam int OUT_SEL_W = 6;

  // selector codes
  localparam logic [7:0] SEL_GROUND = 8'h00;
  localparam logic [7:0] SEL_CMP_LO = 8'h01;
  localparam logic [7:0] SEL_CMP_HI = 8'h03;
  localparam logic [7:0] SEL_TRG_LO = 8'h06;
  localparam logic [7:0] SEL_TRG_HI = 8'h07;
  localparam logic [7:0] SEL_PWM_LO = 8'h0B;
  localparam logic [7:0] SEL_PWM_HI = 8'h0D;
  localparam logic [7:0] SEL_PB_LO = 8'h20;
  localparam logic [7:0] SEL_PB_HI = 8'h2F;
  localparam logic [7:0] SEL_PC_LO = 8'h30;
  localparam logic [7:0] SEL_PC_HI = 8'h3D;
  localparam logic [7:0] SEL_PD1 = 8'h41;
  localparam logic [7:0] SEL_PD8 = 8'h48;
  localparam logic [7:0] SEL_PD10 = 8'h4A;
  localparam logic [7:0] SEL_PD13 = 8'h4D;
  localparam logic [7:0] SEL_VP_LO = 8'hB0;
  localparam logic [7:0] SEL_VP_HI = 8'hB5;

  // layout of the synchronised source vector
  localparam int SRC_W = 48;
  localparam logic [5:0] SRC_CMP = 6'h00;
  localparam logic [5:0] SRC_TRG = 6'h03;
  localparam logic [5:0] SRC_PWM = 6'h05;
  localparam logic [5:0] SRC_PB = 6'h08;
  localparam logic [5:0] SRC_PC = 6'h18;
  localparam logic [5:0] SRC_PD = 6'h26;
  localparam logic [5:0] SRC_VP = 6'h2A;

  // port D bits that are remappable
  localparam int PD_BIT_A = 1;
  localparam int PD_BIT_B = 8;
  localparam int PD_BIT_C = 10;
  localparam int PD_BIT_D = 13;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_ARMED = 2'b10
  } rimp_key_t;

  function automatic logic [5:0] rimp_offset(input logic [7:0] sel,
                                             input logic [7:0] lo,
                                             input logic [5:0] base);
    logic [7:0] d;
    d = sel - lo;
    return base + d[5:0];
  endfunction

endpackage

// ==== core/rimp_src_mux.sv ====
`timescale 1ns/1ps
module rimp_src_mux
  import rimp_pkg::*;
(
  input wire logic [7:0] sel_in,
  input wire logic [SRC_W-1:0] src_in,
  output logic bit_out
);

  logic [5:0] idx;
  logic hit;

  always_comb begin
    idx = 6'h00;
    hit = 1'b1;
    if (sel_in >= SEL_CMP_LO && sel_in <= SEL_CMP_HI) begin
      idx = rimp_offset(sel_in, SEL_CMP_LO, SRC_CMP);
    end else if (sel_in >= SEL_TRG_LO && sel_in <= SEL_TRG_HI) begin
      idx = rimp_offset(sel_in, SEL_TRG_LO, SRC_TRG);
    end else if (sel_in >= SEL_PWM_LO && sel_in <= SEL_PWM_HI) begin
      idx = rimp_offset(sel_in, SEL_PWM_LO, SRC_PWM);
    end else if (sel_in >= SEL_PB_LO && sel_in <= SEL_PB_HI) begin
      idx = rimp_offset(sel_in, SEL_PB_LO, SRC_PB);
    end else if (sel_in >= SEL_PC_LO && sel_in <= SEL_PC_HI) begin
      idx = rimp_offset(sel_in, SEL_PC_LO, SRC_PC);
    end else if (sel_in == SEL_PD1) begin
      idx = SRC_PD;
    end else if (sel_in == SEL_PD8) begin
      idx = SRC_PD + 6'h01;
    end else if (sel_in == SEL_PD10) begin
      idx = SRC_PD + 6'h02;
    end else if (sel_in == SEL_PD13) begin
      idx = SRC_PD + 6'h03;
    end else if (sel_in >= SEL_VP_LO && sel_in <= SEL_VP_HI) begin
      idx = rimp_offset(sel_in, SEL_VP_LO, SRC_VP);
    end else begin
      // ground code and reserved codes both land here
      hit = 1'b0;
    end
    bit_out = hit & src_in[idx];
  end

endmodule

// ==== core/rimp_top.sv ====
`timescale 1ns/1ps
module rimp_top
  import rimp_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int NUM_OUT = 8
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic WR_EN_IN,
  input wire logic [1:0] WR_KIND_IN,
  input wire logic [7:0] WR_IDX_IN,
  input wire logic [15:0] WR_DATA_IN,
  input wire logic [2:0] CMP_IN,
  input wire logic [1:0] TRIG_GEN_IN,
  input wire logic [2:0] PWM_EVENT_IN,
  input wire logic [15:0] PORT_B_IN,
  input wire logic [13:0] PORT_C_IN,
  input wire logic [15:0] PORT_D_IN,
  input wire logic [5:0] VIRT_PIN_IN,
  output logic [NUM_IN-1:0] PERIPH_IN_OUT,
  output logic [NUM_IN*IN_SEL_W-1:0] IN_SEL_OUT,
  output logic [NUM_OUT*OUT_SEL_W-1:0] OUT_SEL_OUT,
  output logic LOCK_OUT,
  output logic WR_ACK_OUT
);

  typedef struct packed {
    logic [NUM_IN-1:0][IN_SEL_W-1:0] in_sel;
    logic [NUM_OUT-1:0][OUT_SEL_W-1:0] out_sel;
    logic lock;
    rimp_key_t key;
    logic ack;
    logic [SRC_W-1:0] sync1;
    logic [SRC_W-1:0] sync2;
    logic [NUM_IN-1:0] periph;
  } rimp_state_t;

  rimp_state_t st;
  rimp_state_t next_st;
  logic [SRC_W-1:0] src_raw;
  logic [NUM_IN-1:0] mux_bit;

  // pins and comparator levels are asynchronous, so all sources are synced
  assign src_raw = {VIRT_PIN_IN,
                    PORT_D_IN[PD_BIT_D], PORT_D_IN[PD_BIT_C],
                    PORT_D_IN[PD_BIT_B], PORT_D_IN[PD_BIT_A],
                    PORT_C_IN, PORT_B_IN, PWM_EVENT_IN, TRIG_GEN_IN,
                    CMP_IN};

  ////////////////////////////////////////////////////////////////////////////

  for (genvar g = 0; g < NUM_IN; g++) begin : g_mux
    rimp_src_mux u_mux (
      .sel_in(st.in_sel[g]),
      .src_in(st.sync2),
      .bit_out(mux_bit[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st = st;
    next_st.sync1 = src_raw;
    next_st.sync2 = st.sync1;
    next_st.periph = mux_bit;
    // every write is answered the same way, locked or not
    next_st.ack = WR_EN_IN;
    if (WR_EN_IN) begin
      // any write other than the next key byte or a fresh 0x55 key write breaks an unfinished key sequence
      next_st.key = KEY_IDLE;
      case (st.key)
        KEY_IDLE: begin
          if (WR_KIND_IN == WR_KEY && WR_DATA_IN[7:0] == KEY_FIRST) begin
            next_st.key = KEY_GOT_FIRST;
          end
        end
        KEY_GOT_FIRST: begin
          if (WR_KIND_IN == WR_KEY && WR_DATA_IN[7:0] == KEY_SECOND) begin
            next_st.key = KEY_ARMED;
          end else if (WR_KIND_IN == WR_KEY &&
                       WR_DATA_IN[7:0] == KEY_FIRST) begin
            next_st.key = KEY_GOT_FIRST;
          end
        end
        KEY_ARMED: begin
          if (WR_KIND_IN == WR_CTRL) begin
            next_st.lock = WR_DATA_IN[LOCK_BIT];
          end else if (WR_KIND_IN == WR_KEY &&
                       WR_DATA_IN[7:0] == KEY_FIRST) begin
            next_st.key = KEY_GOT_FIRST;
          end
        end
        default: begin
          next_st.key = KEY_IDLE;
        end
      endcase
      // locked map writes are silently dropped
      if (!st.lock) begin
        if (WR_KIND_IN == WR_IN_MAP && 32'(WR_IDX_IN) < NUM_IN) begin
          next_st.in_sel[WR_IDX_IN] = WR_DATA_IN[7:0];
        end
        if (WR_KIND_IN == WR_OUT_MAP && 32'(WR_IDX_IN) < NUM_OUT) begin
          next_st.out_sel[WR_IDX_IN] = WR_DATA_IN[5:0];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
      st.in_sel <= {NUM_IN{IN_SEL_RST}};
      st.out_sel <= {NUM_OUT{OUT_SEL_RST}};
      st.lock <= LOCK_RST;
      st.key <= KEY_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign PERIPH_IN_OUT = st.periph;
  assign IN_SEL_OUT = st.in_sel;
  assign OUT_SEL_OUT = st.out_sel;
  assign LOCK_OUT = st.lock;
  assign WR_ACK_OUT = st.ack;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_locked_in_hold: assert property (
    (st.lock && WR_EN_IN && WR_KIND_IN == WR_IN_MAP) |=> $stable(st.in_sel))
    else $error("input map changed while locked");

  a_locked_out_hold: assert property (
    (st.lock && WR_EN_IN && WR_KIND_IN == WR_OUT_MAP)
      |=> ($stable(st.out_sel) && WR_ACK_OUT))
    else $error("locked output map write not quiet");

  a_unlocked_store: assert property (
    (!st.lock && WR_EN_IN && WR_KIND_IN == WR_IN_MAP && WR_IDX_IN == 8'h00)
      |=> st.in_sel[0] == $past(WR_DATA_IN[7:0]))
    else $error("unlocked input map write lost");

  a_lock_needs_key: assert property (
    (st.lock != $past(st.lock)) |-> $past(st.key == KEY_ARMED))
    else $error("lock changed without key sequence");

  a_key_sequence: assert property (
    (st.key == KEY_IDLE && WR_EN_IN && WR_KIND_IN == WR_KEY &&
     WR_DATA_IN[7:0] == KEY_FIRST)
      ##1 (WR_EN_IN && WR_KIND_IN == WR_KEY && WR_DATA_IN[7:0] == KEY_SECOND)
      ##1 (WR_EN_IN && WR_KIND_IN == WR_CTRL)
      |=> LOCK_OUT == $past(WR_DATA_IN[LOCK_BIT]))
    else $error("key sequence did not move the lock");

  a_ground_sel: assert property (
    (st.in_sel[0] == SEL_GROUND) |=> !PERIPH_IN_OUT[0])
    else $error("ground selector not low");

  a_port_b_route: assert property (
    (st.in_sel[0] == SEL_PB_LO) |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_PB]))
    else $error("port B pin 0 not routed");

  a_virtual_route: assert property (
    (st.in_sel[0] == SEL_VP_HI)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_W-1]))
    else $error("virtual pin 5 not routed");

  a_reserved_low: assert property (
    (st.in_sel[0] == 8'h04 || st.in_sel[0] == 8'hB6) |=> !PERIPH_IN_OUT[0])
    else $error("reserved selector not low");

  ////////////////////////////////////////////////////////////////////////////

  // the key check above needs three writes in a row; this one does not
  a_armed_ctrl: assert property (
    (st.key == KEY_ARMED && WR_EN_IN && WR_KIND_IN == WR_CTRL)
      |=> LOCK_OUT == $past(WR_DATA_IN[LOCK_BIT]))
    else $error("armed control write did not move the lock");

  a_lock_one_write: assert property (
    (st.lock != $past(st.lock))
      |-> $past(WR_EN_IN && WR_KIND_IN == WR_CTRL))
    else $error("lock changed without a control write");

  a_other_write_idle: assert property (
    (WR_EN_IN && WR_KIND_IN != WR_KEY) |=> st.key == KEY_IDLE)
    else $error("key sequence survived a foreign write");

  a_ack_follows: assert property (
    WR_ACK_OUT == $past(WR_EN_IN))
    else $error("write acknowledge out of step");

  a_unlocked_out: assert property (
    (!st.lock && WR_EN_IN && WR_KIND_IN == WR_OUT_MAP &&
     WR_IDX_IN == 8'(NUM_OUT - 1))
      |=> st.out_sel[NUM_OUT-1] == $past(WR_DATA_IN[5:0]))
    else $error("unlocked output map write lost");

  // spot checks on field 0 only; the other codes are swept by the bench
  a_cmp_route: assert property (
    (st.in_sel[0] == SEL_CMP_LO)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_CMP]))
    else $error("comparator 1 not routed");

  a_trg_route: assert property (
    (st.in_sel[0] == SEL_TRG_HI)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_TRG + 6'h01]))
    else $error("trigger output 27 not routed");

  a_pwm_route: assert property (
    (st.in_sel[0] == SEL_PWM_HI)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_PWM + 6'h02]))
    else $error("PWM event E not routed");

  a_port_c_route: assert property (
    (st.in_sel[0] == SEL_PC_HI)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_PC + 6'h0D]))
    else $error("port C pin 13 not routed");

  a_port_d_route: assert property (
    (st.in_sel[0] == SEL_PD13)
      |=> PERIPH_IN_OUT[0] == $past(st.sync2[SRC_PD + 6'h03]))
    else $error("port D pin 13 not routed");

endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import rimp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] idx = 8'h00;
  logic [15:0] data = 16'h0000;
  logic [2:0] cmp = 3'h0;
  logic [2:0] pwm = 3'h0;
  logic [1:0] trg = 2'h0;
  logic [15:0] pb = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic [13:0] pc = 14'h0000;
  logic [5:0] vp = 6'h00;
  logic [7:0] periph;
  logic [63:0] in_sel;
  logic [47:0] out_sel;
  logic lock;
  logic ack;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  rimp_top DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr_en),
    .WR_KIND_IN(kind), .WR_IDX_IN(idx), .WR_DATA_IN(data), .CMP_IN(cmp),
    .TRIG_GEN_IN(trg), .PWM_EVENT_IN(pwm), .PORT_B_IN(pb),
    .PORT_C_IN(pc), .PORT_D_IN(pd), .VIRT_PIN_IN(vp),
    .PERIPH_IN_OUT(periph), .IN_SEL_OUT(in_sel), .OUT_SEL_OUT(out_sel),
    .LOCK_OUT(lock), .WR_ACK_OUT(ack));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // sweep plus lock tests need about 2600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // wait one edge, then one write held for one cycle; ack must follow every write
  task automatic wr(input logic [1:0] k, input logic [7:0] i,
                    input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    kind <= k;
    idx <= i;
    data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 chk("ack", 64'h1, {63'h0, ack});
  endtask

  function automatic logic exp_bit(input logic [7:0] s);
    int v;
    v = s;
    if (v >= 1 && v <= 3) return cmp[v-1];
    if (v == 6 || v == 7) return trg[v-6];
    if (v >= 11 && v <= 13) return pwm[v-11];
    if (v >= 32 && v <= 47) return pb[v-32];
    if (v >= 48 && v <= 61) return pc[v-48];
    if (v == 65 || v == 72 || v == 74 || v == 77) return pd[v-64];
    if (v >= 176 && v <= 181) return vp[v-176];
    return 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("in_sel", 64'h0, in_sel);
    chk("out_sel", 64'h0, {16'h0, out_sel});
    chk("lock", 64'h0, {63'h0, lock});
  endtask

  // inverted second pass catches a route stuck at ground or another constant level
  task automatic t_route();
    logic inv;
    for (int p = 0; p < 2; p++) begin
      inv = p[0];
      @(posedge clk);
      cmp <= 3'h5 ^ {3{inv}};
      trg <= 2'h1 ^ {2{inv}};
      pwm <= 3'h2 ^ {3{inv}};
      pb <= 16'hA5C3 ^ {16{inv}};
      pc <= 14'h1B2D ^ {14{inv}};
      pd <= 16'h0402 ^ {16{inv}};
      vp <= 6'h2B ^ {6{inv}};
      for (int s = 0; s < 256; s++) begin
        wr(WR_IN_MAP, 8'h00, {8'h00, 8'(s)});
        repeat (3) @(posedge clk);
        #1 chk("sel0", 64'(s), {56'h0, in_sel[7:0]});
        chk("route0", {63'h0, exp_bit(8'(s))}, {63'h0, periph[0]});
      end
    end
  endtask

  task automatic t_lock();
    // port B bit 0 high so the final route check can tell 0x20 from ground
    @(posedge clk);
    pb <= 16'h0001;
    wr(WR_OUT_MAP, 8'h07, 16'h002A);
    chk("out7", 64'h2A, {58'h0, out_sel[47:42]});
    @(posedge clk);
    #1 chk("ack_end", 64'h0, {63'h0, ack});
    wr(WR_KEY, 8'h00, 16'h0055);
    wr(WR_KEY, 8'h00, 16'h00AA);
    wr(WR_CTRL, 8'h00, 16'h0800);
    chk("lock_set", 64'h1, {63'h0, lock});
    wr(WR_IN_MAP, 8'h07, 16'h0020);
    wr(WR_OUT_MAP, 8'h07, 16'h0011);
    chk("in7_locked", 64'h0, {56'h0, in_sel[63:56]});
    chk("out7_locked", 64'h2A, {58'h0, out_sel[47:42]});
    wr(WR_CTRL, 8'h00, 16'h0000);
    chk("no_key", 64'h1, {63'h0, lock});
    wr(WR_KEY, 8'h00, 16'h00AA);
    wr(WR_KEY, 8'h00, 16'h0055);
    wr(WR_CTRL, 8'h00, 16'h0000);
    chk("wrong_order", 64'h1, {63'h0, lock});
    wr(WR_KEY, 8'h00, 16'h0055);
    wr(WR_KEY, 8'h00, 16'h00AA);
    wr(WR_IN_MAP, 8'h01, 16'h0001);
    wr(WR_CTRL, 8'h00, 16'h0000);
    chk("broken_seq", 64'h1, {63'h0, lock});
    wr(WR_KEY, 8'h00, 16'h0055);
    wr(WR_KEY, 8'h00, 16'h00AA);
    wr(WR_CTRL, 8'h00, 16'hF7FF);
    chk("lock_clr", 64'h0, {63'h0, lock});
    wr(WR_IN_MAP, 8'h07, 16'h0020);
    repeat (2) @(posedge clk);
    #1 chk("in7_open", 64'h20, {56'h0, in_sel[63:56]});
    chk("route7", {63'h0, pb[0]}, {63'h0, periph[7]});
  endtask

  // back-to-back key writes, then a reset taken while locked
  task automatic t_burst_rst();
    @(posedge clk);
    wr_en <= 1'b1;
    kind <= WR_KEY;
    data <= 16'h0055;
    @(posedge clk);
    data <= 16'h00AA;
    @(posedge clk);
    kind <= WR_CTRL;
    data <= 16'h0800;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 chk("burst_lock", 64'h1, {63'h0, lock});
    chk("burst_ack", 64'h1, {63'h0, ack});
    @(posedge clk);
    #1 chk("burst_ack_end", 64'h0, {63'h0, ack});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("rst_lock", 64'h0, {63'h0, lock});
    chk("rst_in", 64'h0, in_sel);
    chk("rst_out", 64'h0, {16'h0, out_sel});
    wr(WR_OUT_MAP, 8'h03, 16'h0015);
    chk("out3_after_rst", 64'h15, {58'h0, out_sel[23:18]});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    t_route();
    t_lock();
    t_burst_rst();
    give_verdict();
  end
endmodule
